// File: design/rate_readout_pkg.sv
// Package with the constants of the rate readout serial responder.
package rate_readout_pkg;

  // Fixed byte returned whenever real data cannot be given.
  localparam logic [7:0] ERROR_CODE = 8'h80;
  // Upper nibble of every low-byte rate answer with data, a check pattern for the host.
  localparam logic [3:0] LOW_CHECK_NIBBLE = 4'h5;

  // Command opcodes as they arrive in the last byte of a transfer.
  localparam logic [7:0] READ_RATE_HIGH_CMD    = 8'h80;
  localparam logic [7:0] READ_RATE_LOW_EXT_CMD = 8'h8E;
  localparam logic [7:0] READ_TEMPERATURE_CMD  = 8'hB0;
  localparam logic [7:0] READ_STATUS_CMD       = 8'hB4;
  localparam logic [7:0] GUARD_OFF_1_CMD       = 8'h4E;
  localparam logic [7:0] GUARD_OFF_2_CMD       = 8'h63;
  localparam logic [7:0] GUARD_OFF_3_CMD       = 8'h12;
  localparam logic [7:0] GUARD_ON_CMD          = 8'h55;
  localparam logic [7:0] PROCESS_RESUME_CMD    = 8'hAA;

  // Address bytes that must precede the guard disable commands.
  localparam logic [7:0] GUARD_OFF_1_ADDR = 8'hD7;
  localparam logic [7:0] GUARD_OFF_2_ADDR = 8'h50;
  localparam logic [7:0] GUARD_OFF_3_ADDR = 8'hA8;

  // Answers of the guard and resume commands.
  localparam logic [7:0] GUARD_OFF_RESP = 8'h80;
  localparam logic [7:0] GUARD_ON_RESP  = 8'h00;
  localparam logic [7:0] RESUME_RESP    = 8'h80;

  // Status flags whose zero value forces the error code on rate reads.
  localparam logic [7:0] FLAG_ERROR_MASK = 8'hEE;

  // Saturation limits of the 12-bit rate word, +2032 and -2032.
  localparam logic [11:0] RATE_MAX = 12'h7F0;
  localparam logic [11:0] RATE_MIN = 12'h810;
  localparam int          RATE_WIDTH = 12;

  // Bit counts of one command byte and of an address plus command.
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h10;

  // Clock figures and the timing counts derived from them.
  localparam int MCLK_PERIOD_NS     = 8;
  localparam int MCLK_HZ            = 125000000;
  localparam int STROBE_GAP_NS      = 527;
  localparam int STROBE_GAP_CYCLES  = (STROBE_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SAMPLE_RATE_HZ     = 2000;
  localparam int REFRESH_CYCLES     = MCLK_HZ / SAMPLE_RATE_HZ;

  // Depth of the sample buffer in front of the readout register.
  localparam int FIFO_DEPTH = 16;

endpackage

// File: design/rate_readout_serial_responder.sv
// Serial responder of the rate sensor with its sample buffer.
//
// Function
// - Address byte precedes command byte in one transfer.
// - Error code is 1000 0000.
// - Error code answers everything during start-up.
// - Undefined or illegal opcodes answer error code.
// - Rate reads give error code on zero flag; code checks only flags in mask 8'hEE, bits 4 and 0 are ignored.
// - Rate high read gives top eight bits.
// - Negative rate samples saturate at -2032.
// - Positive rate samples saturate at +2032.
// - Saturation leaves every status flag untouched.
// - Rate low read gives 0101 and low nibble.
// - Rate high read latches same sample's low nibble.
// - Sample input on rising, shift output on falling.
// - Fewer than eight bits: transfer discarded, nothing executed.
`timescale 1ns/1ps

// First-in first-out buffer with valid and ready on both sides.
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
  logic [AW:0]      wr_ptr_q;       // Write pointer with wrap bit.
  logic [AW:0]      rd_ptr_q;       // Read pointer with wrap bit.
  wire              full_w  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                              (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire              empty_w = (wr_ptr_q == rd_ptr_q);
  wire              push_w  = wr_valid_in && !full_w;
  wire              pop_w   = rd_ready_in && !empty_w;

  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  assign rd_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  // Pointers move on accepted pushes and pops only.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  // The storage needs no reset; a word is only read after it was written.
  always_ff @(posedge mclk_in) begin
    if (push_w) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
    end
  end
endmodule

// Serial responder: command decode, answer selection and shift logic.
module rate_readout_serial_responder #(
  parameter int REFRESH_CYCLES = rate_readout_pkg::REFRESH_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        strobe_n_in,
  input  wire logic        sclk_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        sample_valid_in,
  input  wire logic [11:0] sample_in,
  output logic             sample_ready_out,
  input  wire logic [7:0]  temperature_in,
  input  wire logic [7:0]  status_flags_in,
  input  wire logic        startup_done_in
);
  // Pin synchronisers; stage one feeds stage two only, stage three is history.
  logic strobe_s1_q, strobe_s2_q, strobe_s3_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic mosi_s1_q, mosi_s2_q;

  logic [4:0]  bit_cnt_q;      // Received bits, saturating at sixteen.
  logic [15:0] in_shift_q;     // Address byte above, command byte below.
  logic [7:0]  out_shift_q;    // Data output shift register.
  logic [7:0]  resp_q;         // Data register with the pending answer.
  logic        miso_oe_q;      // Drive enable of the data output.
  logic [3:0]  low_latch_q;    // Low nibble captured by a rate high read.
  logic [11:0] cur_sample_q;   // Clamped sample presented for readout.
  logic [31:0] refresh_cnt_q;  // Divider of the sample refresh tick.
  logic        refresh_due_q;  // A refresh is waiting for the strobe to be high and a buffered sample.

  // Edge detection works on the second and third stages only.
  wire strobe_fall_w = strobe_s3_q && !strobe_s2_q;
  wire strobe_rise_w = !strobe_s3_q && strobe_s2_q;
  wire sclk_rise_w   = !sclk_s3_q && sclk_s2_q && !strobe_s2_q;
  wire sclk_fall_w   = sclk_s3_q && !sclk_s2_q && !strobe_s2_q;

  // Command decoding; the opcode is always the last byte shifted in.
  wire [7:0] cmd_w      = in_shift_q[7:0];
  wire [7:0] addr_w     = in_shift_q[15:8];
  wire       has_addr_w = (bit_cnt_q >= rate_readout_pkg::ADDR_BITS);
  wire       exec_w     = strobe_rise_w && (bit_cnt_q >= rate_readout_pkg::CMD_BITS);
  wire is_high_w  = (cmd_w == rate_readout_pkg::READ_RATE_HIGH_CMD);
  wire is_low_w   = (cmd_w == rate_readout_pkg::READ_RATE_LOW_EXT_CMD);
  wire is_temp_w  = (cmd_w == rate_readout_pkg::READ_TEMPERATURE_CMD);
  wire is_stat_w  = (cmd_w == rate_readout_pkg::READ_STATUS_CMD);
  wire is_on_w    = (cmd_w == rate_readout_pkg::GUARD_ON_CMD);
  wire is_res_w   = (cmd_w == rate_readout_pkg::PROCESS_RESUME_CMD);
  // Guard disable commands only count with their address byte in front.
  wire off1_w     = (cmd_w == rate_readout_pkg::GUARD_OFF_1_CMD) &&
                    (addr_w == rate_readout_pkg::GUARD_OFF_1_ADDR);
  wire off2_w     = (cmd_w == rate_readout_pkg::GUARD_OFF_2_CMD) &&
                    (addr_w == rate_readout_pkg::GUARD_OFF_2_ADDR);
  wire off3_w     = (cmd_w == rate_readout_pkg::GUARD_OFF_3_CMD) &&
                    (addr_w == rate_readout_pkg::GUARD_OFF_3_ADDR);
  wire is_off_w   = has_addr_w && (off1_w || off2_w || off3_w);
  wire known_w    = is_high_w || is_low_w || is_temp_w || is_stat_w ||
                    is_on_w || is_res_w || is_off_w;
  wire flags_bad_w = |(~status_flags_in & rate_readout_pkg::FLAG_ERROR_MASK);
  wire rate_err_w  = (is_high_w || is_low_w) && flags_bad_w;

  // Answer selection; start-up and illegal opcodes win over all data.
  wire [7:0] resp_d =
    !startup_done_in ? rate_readout_pkg::ERROR_CODE :
    !known_w         ? rate_readout_pkg::ERROR_CODE :
    rate_err_w       ? rate_readout_pkg::ERROR_CODE :
    is_high_w        ? cur_sample_q[11:4] :
    is_low_w         ? {rate_readout_pkg::LOW_CHECK_NIBBLE, low_latch_q} :
    is_temp_w        ? temperature_in :
    is_stat_w        ? status_flags_in :
    is_on_w          ? rate_readout_pkg::GUARD_ON_RESP :
    is_res_w         ? rate_readout_pkg::RESUME_RESP :
                       rate_readout_pkg::GUARD_OFF_RESP;

  // Sample buffer between the filter output and the readout register.
  logic        fifo_valid_w;
  logic [11:0] fifo_data_w;
  wire         pop_w = refresh_due_q && fifo_valid_w && strobe_s2_q;

  sample_fifo #(
    .WIDTH (rate_readout_pkg::RATE_WIDTH),
    .DEPTH (rate_readout_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (sample_valid_in),
    .wr_data_in   (sample_in),
    .wr_ready_out (sample_ready_out),
    .rd_valid_out (fifo_valid_w),
    .rd_data_out  (fifo_data_w),
    .rd_ready_in  (pop_w)
  );

  // Saturation keeps the high byte away from the error pattern.
  wire below_w = $signed(fifo_data_w) < $signed(rate_readout_pkg::RATE_MIN);
  wire above_w = $signed(fifo_data_w) > $signed(rate_readout_pkg::RATE_MAX);
  // Clamping works on the data word alone; status flags are never touched.
  wire [11:0] clamped_w = below_w ? rate_readout_pkg::RATE_MIN :
                          above_w ? rate_readout_pkg::RATE_MAX : fifo_data_w;

  assign miso_out    = out_shift_q[7];
  assign miso_oe_out = miso_oe_q;

  // Two flip-flop synchronisers for the link pins plus a history stage on strobe and clock.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      {strobe_s1_q, strobe_s2_q, strobe_s3_q} <= 3'h7;
      {sclk_s1_q, sclk_s2_q, sclk_s3_q}       <= 3'h0;
      {mosi_s1_q, mosi_s2_q}                  <= 2'h0;
    end else begin
      {strobe_s1_q, strobe_s2_q, strobe_s3_q} <= {strobe_n_in, strobe_s1_q, strobe_s2_q};
      {sclk_s1_q, sclk_s2_q, sclk_s3_q}       <= {sclk_in, sclk_s1_q, sclk_s2_q};
      {mosi_s1_q, mosi_s2_q}                  <= {mosi_in, mosi_s1_q};
    end
  end

  // Input shifting; a new transfer clears the bit count.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      bit_cnt_q  <= 5'h00;
      in_shift_q <= 16'h0000;
    end else if (strobe_fall_w) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise_w) begin
      in_shift_q <= {in_shift_q[14:0], mosi_s2_q};
      if (bit_cnt_q < rate_readout_pkg::ADDR_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Output shifting; the data register is copied at the start of a transfer.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      out_shift_q <= 8'h00;
      miso_oe_q   <= 1'b0;
    end else begin
      miso_oe_q <= !strobe_s2_q;
      if (strobe_fall_w) begin
        out_shift_q <= resp_q;
      end else if (sclk_fall_w) begin
        out_shift_q <= {out_shift_q[6:0], 1'b0};
      end
    end
  end

  // Execution at strobe rise; the answer is ready one cycle later,
  // far inside the host's minimum high time, so no extra wait is needed.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      resp_q      <= rate_readout_pkg::ERROR_CODE;
      low_latch_q <= 4'h0;
    end else if (exec_w) begin
      resp_q <= resp_d;
      if (is_high_w) begin
        low_latch_q <= cur_sample_q[3:0];
      end
    end
  end

  // Refresh divider; a due refresh waits while a transfer is running.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      refresh_cnt_q <= 32'h0000_0000;
      refresh_due_q <= 1'b0;
      cur_sample_q  <= 12'h000;
    end else begin
      if (refresh_cnt_q == 32'(REFRESH_CYCLES - 1)) begin
        refresh_cnt_q <= 32'h0000_0000;
        refresh_due_q <= 1'b1;
      end else begin
        refresh_cnt_q <= refresh_cnt_q + 32'h0000_0001;
        if (pop_w) begin
          refresh_due_q <= 1'b0;
        end
      end
      if (pop_w) begin
        cur_sample_q <= clamped_w;
      end
    end
  end

  // Checker history: a high read has run, and the low nibble of its sample.
  // Kept apart from the latch itself so the pairing check is not circular.
  logic       high_seen_q;  // At least one rate high read has executed.
  logic [3:0] high_nib_q;   // Low nibble of the sample at the last high read.

  // The history follows every executed high read, error answers included.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      high_seen_q <= 1'b0;
      high_nib_q  <= 4'h0;
    end else if (exec_w && is_high_w) begin
      high_seen_q <= 1'b1;
      high_nib_q  <= cur_sample_q[3:0];
    end
  end

  // A high read followed, in a later transfer, by a low read.
  sequence seq_high_read;
    exec_w && is_high_w && startup_done_in && !flags_bad_w;
  endsequence
  sequence seq_low_read;
    exec_w && is_low_w && startup_done_in && !flags_bad_w;
  endsequence

  AST_STARTUP_ERROR: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    exec_w && !startup_done_in |=> resp_q == 8'h80)
    else $error("Answer during start-up is not the error code.");

  AST_UNDEFINED_ERROR: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    exec_w && !known_w |=> resp_q == 8'h80)
    else $error("Undefined opcode did not answer the error code.");

  AST_FLAG_ERROR: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    exec_w && (is_high_w || is_low_w) && flags_bad_w |=> resp_q == 8'h80)
    else $error("Rate read with a zero flag gave data.");

  AST_HIGH_BYTE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    seq_high_read |=> resp_q == $past(cur_sample_q[11:4]))
    else $error("Rate high answer is not the sample's top byte.");

  AST_SAME_SAMPLE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    high_seen_q ##0 seq_low_read |=> resp_q == {4'h5, high_nib_q})
    else $error("Low answer does not pair with the latched sample.");

  AST_CLAMP_NEG: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    pop_w && below_w |=> cur_sample_q == 12'h810)
    else $error("Negative sample not saturated at -2032.");

  AST_CLAMP_POS: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    pop_w && above_w |=> cur_sample_q == 12'h7F0)
    else $error("Positive sample not saturated at +2032.");

  AST_SHORT_DISCARD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    strobe_rise_w && bit_cnt_q < 5'h08 |=> $stable(resp_q) && $stable(low_latch_q))
    else $error("Short transfer changed the answer.");

  AST_MISO_EDGE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $past(nrst_in) && $changed(out_shift_q) |-> $past(strobe_fall_w) || $past(sclk_fall_w))
    else $error("Output data moved outside a falling clock or strobe edge.");

  AST_TEMPERATURE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    exec_w && is_temp_w && startup_done_in |=> resp_q == $past(temperature_in))
    else $error("Temperature answer differs from the temperature input.");
endmodule

// File: tb/serial_host_model.sv
// Behavioural serial master that drives transfers into the responder.
`timescale 1ns/1ps

module serial_host_model (
  input  wire logic mclk_in,
  output logic      strobe_n_out,
  output logic      sclk_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // The link idles with strobe high and the serial clock low.
  initial begin
    strobe_n_out = 1'b1;
    sclk_out     = 1'b0;
    mosi_out     = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // One transfer, last bits sent are the command, earlier ones the address.
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] resp);
    resp = 8'h00;
    @(posedge mclk_in);
    strobe_n_out <= 1'b0;
    wait_clk(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_out <= word[i]; // Data changes while the clock is low.
      wait_clk(3);
      @(negedge mclk_in);
      resp = {resp[6:0], miso_in}; // Answer is taken just before the rise.
      @(posedge mclk_in);
      sclk_out <= 1'b1;
      wait_clk(4);
      sclk_out <= 1'b0;
    end
    wait_clk(4);
    strobe_n_out <= 1'b1;
    mosi_out     <= ~mosi_out; // Released data line must not keep its value.
    wait_clk(72); // Gap above 66 cycles keeps the strobe high long enough.
  endtask

  // Holds the strobe low with no clocks, for buffer tests.
  task automatic hold();
    @(posedge mclk_in);
    strobe_n_out <= 1'b0;
  endtask

  // Ends a held transfer with no bits shifted.
  task automatic release_strobe();
    @(posedge mclk_in);
    strobe_n_out <= 1'b1;
    wait_clk(72); // Gap kept as for a full transfer.
  endtask
endmodule

// File: tb/tb_rate_readout_serial_responder.sv
// Self-checking bench of the rate readout serial responder.
`timescale 1ns/1ps

module tb_rate_readout_serial_responder;
  logic        mclk_in;          // System clock.
  logic        nrst_in;          // Synchronous reset, active low.
  logic        sample_valid_in;  // Sample push strobe.
  logic [11:0] sample_in;        // Sample pushed into the buffer.
  logic [7:0]  temperature_in;   // Temperature seen by the responder.
  logic [7:0]  status_flags_in;  // Live status byte.
  logic        startup_done_in;  // Start-up finished.
  wire         strobe_n;         // Transfer strobe from the host.
  wire         sclk;             // Serial clock from the host.
  wire         mosi;             // Host to device data.
  wire         miso;             // Device to host data.
  wire         ready;            // Buffer has room.
  wire         oe;               // Drive enable of the device data output.
  int          fail_count;       // Mismatches seen.
  int          checked;          // Comparisons made.
  int          cycles;           // Clock edges since start.
  int          pushed;           // Words accepted in the fill test.
  logic        room;             // Room sampled before an edge.
  logic [7:0]  ans;              // Answer of the last read.
  logic [7:0]  junk;             // Answer that is not looked at.
  logic [63:0] r;                // Current table row.

  // Row: startup, flags, sample, temperature, command, bit count, expected answer.
  localparam logic [63:0] ROWS [19] = '{
    {4'h0, 8'hFF, 12'h123, 8'h19, 16'h0080, 8'h08, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h0080, 8'h08, 8'h12},
    {4'h1, 8'hFF, 12'h456, 8'h19, 16'h008E, 8'h08, 8'h53},
    {4'h1, 8'hFF, 12'h800, 8'h19, 16'h0080, 8'h08, 8'h81},
    {4'h1, 8'hFF, 12'h800, 8'h19, 16'h008E, 8'h08, 8'h50},
    {4'h1, 8'hFF, 12'h800, 8'h19, 16'h00B4, 8'h08, 8'hFF},
    {4'h1, 8'hFF, 12'h7FF, 8'h19, 16'h0080, 8'h08, 8'h7F},
    {4'h1, 8'hFF, 12'h7FF, 8'h19, 16'h008E, 8'h08, 8'h50},
    {4'h1, 8'hFD, 12'h123, 8'h19, 16'h0080, 8'h08, 8'h80},
    {4'h1, 8'h7F, 12'h123, 8'h19, 16'h008E, 8'h08, 8'h80},
    {4'h1, 8'hEF, 12'h123, 8'h19, 16'h0080, 8'h08, 8'h12},
    {4'h1, 8'hFF, 12'h123, 8'hD8, 16'h00B0, 8'h08, 8'hD8},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h00FF, 8'h08, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'hD74E, 8'h10, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h0055, 8'h08, 8'h00},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h0063, 8'h08, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h00AA, 8'h08, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'h5063, 8'h10, 8'h80},
    {4'h1, 8'hFF, 12'h123, 8'h19, 16'hA812, 8'h10, 8'h80}
  };

  // Short refresh count keeps the run brief.
  rate_readout_serial_responder #(.REFRESH_CYCLES(50)) u_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .strobe_n_in(strobe_n), .sclk_in(sclk),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .sample_ready_out(ready), .temperature_in(temperature_in),
    .status_flags_in(status_flags_in), .startup_done_in(startup_done_in)
  );

  serial_host_model u_host (
    .mclk_in(mclk_in), .strobe_n_out(strobe_n), .sclk_out(sclk), .mosi_out(mosi),
    .miso_in(miso)
  );

  // Free-running system clock, 8 ns period.
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // Compares one answer and reports a difference at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Pushes one sample into the buffer.
  task automatic push(input logic [11:0] v);
    @(posedge mclk_in);
    sample_valid_in <= 1'b1;
    sample_in       <= v;
    @(posedge mclk_in);
    sample_valid_in <= 1'b0;
  endtask

  // Runs a command, then a status read that brings back its answer.
  task automatic ask(input logic [15:0] cmd, input int nb, output logic [7:0] a);
    u_host.xfer(cmd, nb, junk);
    u_host.xfer({8'h00, rate_readout_pkg::READ_STATUS_CMD}, 8, a);
  endtask

  // A hang is cut short by counting edges.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  // Main sequence: reset, table, then the awkward cases.
  initial begin
    nrst_in = 1'b0;
    sample_valid_in = 1'b0;
    sample_in = 12'h000;
    temperature_in = 8'h19;
    status_flags_in = 8'hFF;
    startup_done_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    u_host.wait_clk(4);
    u_host.xfer({8'h00, rate_readout_pkg::READ_STATUS_CMD}, 8, ans);
    check(ans, rate_readout_pkg::ERROR_CODE);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      startup_done_in <= r[60];
      status_flags_in <= r[59:52];
      temperature_in  <= r[39:32];
      push(r[51:40]);
      u_host.wait_clk(120);
      ask(r[31:16], int'(r[15:8]), ans);
      check(ans, r[7:0]);
    end
    // A transfer cut after four bits leaves the last answer in place.
    u_host.xfer(16'h00B0, 8, junk);
    u_host.xfer(16'h0008, 4, junk);
    u_host.xfer(16'h00B4, 8, ans);
    check(ans, 8'h19);
    // Refresh waits while the strobe is low, so the buffer fills up.
    u_host.hold();
    u_host.wait_clk(10);
    check({7'h00, oe}, 8'h01);
    pushed = 0;
    sample_valid_in <= 1'b1;
    sample_in <= 12'h020;
    repeat (20) begin
      @(negedge mclk_in);
      room = ready;
      @(posedge mclk_in);
      if (room === 1'b1) begin
        pushed++;
        sample_in <= 12'h020 + 12'(pushed * 16);
      end
    end
    sample_valid_in <= 1'b0;
    check(8'(pushed), 8'h10);
    u_host.release_strobe();
    check({7'h00, oe}, 8'h00);
    u_host.wait_clk(1000);
    check({7'h00, ready}, 8'h01);
    ask(16'h0080, 8, ans);
    check(ans, 8'h11);
    // A second reset in mid-run restores the reset answer.
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    u_host.wait_clk(2);
    nrst_in <= 1'b1;
    u_host.wait_clk(4);
    u_host.xfer(16'h00B4, 8, ans);
    check(ans, rate_readout_pkg::ERROR_CODE);
    end_sim();
  end
endmodule
